/* File: hdl/input_polarity_select.sv */
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none

module input_polarity_select
    import polarity_pkg::*;
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0]    s_axi_wdata,
    input  wire logic [DATA_W/8-1:0]  s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    // axi4-lite read data
    output logic [DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // external terminal levels
    input  wire logic [NUM_TERMS-1:0] term_in,
    // status toward the controller
    output logic                      valid,
    output logic                      busy,
    output term_state_t               term_state
);

    logic              aw_full_q,  aw_full_d;
    logic              w_full_q,   w_full_d;
    logic [ADDR_W-1:0] awaddr_q,   awaddr_d;
    logic [DATA_W-1:0] wdata_q,    wdata_d;
    logic [3:0]        wstrb_q,    wstrb_d;
    logic              awready_q,  awready_d;
    logic              wready_q,   wready_d;
    logic              bvalid_q,   bvalid_d;
    logic [1:0]        bresp_q,    bresp_d;
    logic              arready_q,  arready_d;
    logic              rvalid_q,   rvalid_d;
    logic [1:0]        rresp_q,    rresp_d;
    logic [DATA_W-1:0] rdata_q,    rdata_d;
    logic              en_q,       en_d;
    pol_set_t          pol_q,      pol_d;
    logic              busy_q,     busy_d;
    logic              valid_q,    valid_d;
    logic [DATA_W-1:0] wr_word;
    logic              run;

    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] data,
                                                input logic [3:0]        strb);
        logic [DATA_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = data[8*i +: 8];
            end
        end
        return r;
    endfunction

    // write channel: address and data taken in either order
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d  = w_full_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        en_d      = en_q;
        pol_d     = pol_q;
        wr_word   = DATA_ZERO;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_full_q && w_full_q && !bvalid_q) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = RESP_OKAY;
            case ({awaddr_q[ADDR_W-1:2], 2'b00})
                CTRL_OFF: begin
                    wr_word = merge({31'h0000_0000, en_q}, wdata_q, wstrb_q);
                    en_d    = wr_word[CTRL_EN_BIT];
                end
                POL_OFF: begin
                    wr_word = merge({14'h0000, pol_q}, wdata_q, wstrb_q);
                    pol_d   = pol_set_t'(wr_word[NUM_TERMS-1:0]);
                end
                STATUS_OFF, STATE_OFF, RAW_OFF: begin
                    wr_word = DATA_ZERO;
                end
                default: begin
                    bresp_d = RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= DATA_ZERO;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            en_q      <= EN_RST;
            pol_q     <= pol_set_t'(POL_RST);
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            en_q      <= en_d;
            pol_q     <= pol_d;
        end
    end

    // read channel
    always_comb begin
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            rdata_d  = DATA_ZERO;
            case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
                CTRL_OFF:   rdata_d[CTRL_EN_BIT] = en_q;
                POL_OFF:    rdata_d[NUM_TERMS-1:0] = pol_q;
                STATUS_OFF: begin
                    rdata_d[STATUS_VALID_BIT] = valid_q;
                    rdata_d[STATUS_BUSY_BIT]  = busy_q;
                end
                STATE_OFF:  rdata_d[NUM_TERMS-1:0] = term_state;
                RAW_OFF:    rdata_d[NUM_TERMS-1:0] = term_in;
                default:    rresp_d = RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= DATA_ZERO;
        end else begin
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    // enable sequencing: busy follows enable, valid one cycle later
    always_comb begin
        busy_d  = en_q;
        valid_d = en_q && busy_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q  <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            busy_q  <= busy_d;
            valid_q <= valid_d;
        end
    end

    // polarity taken fresh every cycle while valid
    assign run = en_q && valid_q;

    term_sense #(
        .W     (NUM_TERMS),
        .RST_V (STATE_RST)
    ) u_sense (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (run),
        .pol     (pol_q),
        .term    (term_in),
        .state_q (term_state)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign busy          = busy_q;
    assign valid         = valid_q;

    sequence s_enable_rise;
        !en_q ##1 en_q;
    endsequence

    sequence s_valid_arrives;
        !valid_q ##1 valid_q;
    endsequence

    property p_busy_follows_enable;
        @(posedge aclk) disable iff (!aresetn)
        en_q |=> busy_q;
    endproperty
    a_busy_follows_enable: assert property (p_busy_follows_enable)
        else $error("busy not high one cycle after enable");

    property p_valid_one_after_busy;
        @(posedge aclk) disable iff (!aresetn)
        s_enable_rise ##1 en_q |-> s_valid_arrives;
    endproperty
    a_valid_one_after_busy: assert property (p_valid_one_after_busy)
        else $error("valid did not rise one cycle after busy");

    property p_valid_needs_busy;
        @(posedge aclk) disable iff (!aresetn)
        valid_q |-> busy_q && $past(busy_q);
    endproperty
    a_valid_needs_busy: assert property (p_valid_needs_busy)
        else $error("valid high before configuration applied");

    property p_disable_clears;
        @(posedge aclk) disable iff (!aresetn)
        !en_q |=> !busy_q && !valid_q && (term_state == STATE_RST);
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("outputs not cleared after enable low");

    property p_state_xor;
        @(posedge aclk) disable iff (!aresetn)
        (en_q && valid_q) |=> term_state == $past(pol_q ^ term_in);
    endproperty
    a_state_xor: assert property (p_state_xor)
        else $error("terminal state is not polarity xor level");

    property p_pol_change_tracked;
        @(posedge aclk) disable iff (!aresetn)
        (en_q && valid_q && $changed(pol_q)) ##1 (en_q && valid_q)
            |-> term_state == $past(pol_q ^ term_in) ##1 term_state == $past(pol_q ^ term_in);
    endproperty
    a_pol_change_tracked: assert property (p_pol_change_tracked)
        else $error("polarity change not applied while valid");

    property p_state_low_when_invalid;
        @(posedge aclk) disable iff (!aresetn)
        !valid_q |=> term_state == STATE_RST;
    endproperty
    a_state_low_when_invalid: assert property (p_state_low_when_invalid)
        else $error("terminal state high without valid");

    property p_pol_reset_low;
        @(posedge aclk)
        !aresetn |=> pol_q == pol_set_t'(POL_RST) && !en_q;
    endproperty
    a_pol_reset_low: assert property (p_pol_reset_low)
        else $error("polarity not low after reset");

endmodule

`default_nettype wire

/* File: hdl/term_sense.sv */
`default_nettype none

module term_sense #(
    parameter int                 W     = 18,
    parameter logic [W-1:0]       RST_V = '0
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // control
    input  wire logic         run,
    // polarity and raw terminal levels
    input  wire logic [W-1:0] pol,
    input  wire logic [W-1:0] term,
    // adjusted terminal states
    output logic      [W-1:0] state_q
);

    logic [W-1:0] state_d;

    always_comb begin
        state_d = '0;
        if (run) begin
            state_d = pol ^ term;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= RST_V;
        end else begin
            state_q <= state_d;
        end
    end

endmodule

`default_nettype wire

/* File: pkg/polarity_pkg.sv */
`default_nettype none

package polarity_pkg;

    localparam int NUM_TERMS = 18;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFF   = 8'h00;
    localparam logic [ADDR_W-1:0] POL_OFF    = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h08;
    localparam logic [ADDR_W-1:0] STATE_OFF  = 8'h0C;
    localparam logic [ADDR_W-1:0] RAW_OFF    = 8'h10;

    // field positions
    localparam int CTRL_EN_BIT      = 0;
    localparam int STATUS_VALID_BIT = 0;
    localparam int STATUS_BUSY_BIT  = 1;

    // reset values
    localparam logic                 EN_RST    = 1'b0;
    localparam logic [NUM_TERMS-1:0] POL_RST   = 18'h0_0000;
    localparam logic [NUM_TERMS-1:0] STATE_RST = 18'h0_0000;
    localparam logic [DATA_W-1:0]    DATA_ZERO = 32'h0000_0000;

    // polarity encodings
    localparam logic SENSE_NORMALLY_OPEN   = 1'b0;
    localparam logic SENSE_NORMALLY_CLOSED = 1'b1;

    // axi4-lite response codes
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // pulse input 0 sits at bit 0, general input 5 at bit 17
    typedef struct packed {
        logic pol_general_in5;
        logic pol_general_in4;
        logic pol_general_in3;
        logic pol_general_in2;
        logic pol_general_in1;
        logic pol_general_in0;
        logic pol_home_in3;
        logic pol_home_in2;
        logic pol_home_in1;
        logic pol_home_in0;
        logic pol_home_in5;
        logic pol_home_in4;
        logic pol_wheel_phase_b;
        logic pol_wheel_phase_a;
        logic pol_pulse_in3;
        logic pol_pulse_in2;
        logic pol_pulse_in1;
        logic pol_pulse_in0;
    } pol_set_t;

    typedef struct packed {
        logic state_general_in5;
        logic state_general_in4;
        logic state_general_in3;
        logic state_general_in2;
        logic state_general_in1;
        logic state_general_in0;
        logic state_home_in3;
        logic state_home_in2;
        logic state_home_in1;
        logic state_home_in0;
        logic state_home_in5;
        logic state_home_in4;
        logic state_wheel_phase_b;
        logic state_wheel_phase_a;
        logic state_pulse_in3;
        logic state_pulse_in2;
        logic state_pulse_in1;
        logic state_pulse_in0;
    } term_state_t;

endpackage

`default_nettype wire

/* File: testbench/ctrl_master.sv */
`default_nettype none

// controller side: register bus master that owns the polarity settings
module ctrl_master
    import polarity_pkg::*;
(
    // clock
    input  wire logic              aclk,
    // write channels
    output logic [ADDR_W-1:0]      awaddr,
    output logic                   awvalid,
    input  wire logic              awready,
    output logic [DATA_W-1:0]      wdata,
    output logic [DATA_W/8-1:0]    wstrb,
    output logic                   wvalid,
    input  wire logic              wready,
    input  wire logic [1:0]        bresp,
    input  wire logic              bvalid,
    // read channels
    output logic [ADDR_W-1:0]      araddr,
    output logic                   arvalid,
    input  wire logic              arready,
    input  wire logic [DATA_W-1:0] rdata,
    input  wire logic [1:0]        rresp,
    input  wire logic              rvalid
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NUM_TERMS-1:0] pol_set = POL_RST;

    initial begin
        awaddr  = '0;
        awvalid = 1'b0;
        wdata   = '0;
        wstrb   = '0;
        wvalid  = 1'b0;
        araddr  = '0;
        arvalid = 1'b0;
    end

    task automatic wr_strb(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                           input logic [DATA_W/8-1:0] s, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        @(posedge aclk);
        aw_p = 1'b1;
        w_p = 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                aw_p = 1'b0;
                awvalid <= 1'b0;
            end
            if (w_p && wready) begin
                w_p = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        r = bresp;
    endtask

    // full-word write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [1:0] r);
        wr_strb(a, d, 4'hF, r);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    // one normally-open/normally-closed bit per terminal
    task automatic set_pol(input logic [NUM_TERMS-1:0] p, output logic [1:0] r);
        pol_set = p;
        wr(POL_OFF, DATA_W'(p), r);
    endtask
endmodule

`default_nettype wire

/* File: testbench/input_polarity_select_tb_top.sv */
`default_nettype none

module input_polarity_select_tb_top import polarity_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 aclk;
    logic                 aresetn;
    logic [ADDR_W-1:0]    awaddr;
    logic                 awvalid;
    logic                 awready;
    logic [DATA_W-1:0]    wdata;
    logic [DATA_W/8-1:0]  wstrb;
    logic                 wvalid;
    logic                 wready;
    logic [1:0]           bresp;
    logic                 bvalid;
    logic [ADDR_W-1:0]    araddr;
    logic                 arvalid;
    logic                 arready;
    logic [DATA_W-1:0]    rdata;
    logic [1:0]           rresp;
    logic                 rvalid;
    logic [NUM_TERMS-1:0] term_in;
    logic                 valid;
    logic                 busy;
    term_state_t          term_state;
    logic [DATA_W-1:0]    rd_d;
    logic [1:0]           rsp;
    logic [NUM_TERMS-1:0] pol;
    logic [NUM_TERMS-1:0] pols [3] = '{18'h3_FFFF, 18'h0_F0F0, 18'h0_0000};
    int                   failures = 0;
    int                   compares = 0;
    int                   cyc = 0;

    input_polarity_select dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .term_in(term_in),
        .valid(valid), .busy(busy), .term_state(term_state)
    );

    ctrl_master ctl (
        .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid)
    );

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic print_verdict();
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic chk_flag(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [DATA_W-1:0] e,
                            input logic [DATA_W-1:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e, input logic [1:0] er);
        ctl.rd(a, rd_d, rsp);
        chk_word(n, e, rd_d);
        chk_word("rresp", DATA_W'(er), DATA_W'(rsp));
    endtask

    task automatic st_chk(input logic b, input logic v, input logic [NUM_TERMS-1:0] s);
        chk_flag("busy", b, busy);
        chk_flag("valid", v, valid);
        chk_word("term_state", DATA_W'(s), DATA_W'(term_state));
    endtask

    // new level lands in term_state at the edge that samples it, one edge after it is driven
    task automatic set_term(input logic [NUM_TERMS-1:0] v);
        @(posedge aclk);
        term_in <= v;
        repeat (2) @(negedge aclk);
    endtask

    initial begin
        aresetn = 1'b0;
        term_in = 18'h0_0000;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        st_chk(1'b0, 1'b0, STATE_RST);
        rd_chk("ctrl", CTRL_OFF, DATA_ZERO, RESP_OKAY);
        rd_chk("pol", POL_OFF, DATA_W'(ctl.pol_set), RESP_OKAY);
        rd_chk("unmapped", 8'h14, DATA_ZERO, RESP_SLVERR);
        ctl.wr(8'h14, 32'hFFFF_FFFF, rsp);
        chk_word("bresp", DATA_W'(RESP_SLVERR), DATA_W'(rsp));
        pol = 18'h2_A5C3;
        ctl.set_pol(pol, rsp);
        set_term(18'h1_3C96);
        st_chk(1'b0, 1'b0, STATE_RST);
        ctl.wr(CTRL_OFF, 32'h0000_0001, rsp);
        @(negedge aclk);
        st_chk(1'b1, 1'b0, STATE_RST);
        @(negedge aclk);
        st_chk(1'b1, 1'b1, STATE_RST);
        @(negedge aclk);
        st_chk(1'b1, 1'b1, pol ^ term_in);
        for (int i = 0; i < NUM_TERMS; i++) begin
            set_term(18'h0_0001 << i);
            st_chk(1'b1, 1'b1, pol ^ term_in);
        end
        set_term(18'h3_FFFF);
        st_chk(1'b1, 1'b1, pol ^ term_in);
        for (int i = 0; i < 3; i++) begin
            pol = pols[i];
            ctl.set_pol(pol, rsp);
            @(negedge aclk);
            st_chk(1'b1, 1'b1, pol ^ term_in);
        end
        rd_chk("pol", POL_OFF, DATA_W'(ctl.pol_set), RESP_OKAY);
        rd_chk("status", STATUS_OFF, 32'h0000_0003, RESP_OKAY);
        rd_chk("state", STATE_OFF, DATA_W'(pol ^ term_in), RESP_OKAY);
        rd_chk("raw", RAW_OFF, DATA_W'(term_in), RESP_OKAY);
        ctl.wr(CTRL_OFF, DATA_ZERO, rsp);
        @(negedge aclk);
        st_chk(1'b0, 1'b0, STATE_RST);
        rd_chk("status", STATUS_OFF, DATA_ZERO, RESP_OKAY);
        ctl.wr(CTRL_OFF, 32'h0000_0001, rsp);
        repeat (3) @(negedge aclk);
        st_chk(1'b1, 1'b1, pol ^ term_in);
        // only byte 2 written: the two top polarity bits go high
        pol = 18'h3_0000;
        ctl.wr_strb(POL_OFF, 32'hFFFF_FFFF, 4'h4, rsp);
        @(negedge aclk);
        st_chk(1'b1, 1'b1, pol ^ term_in);
        rd_chk("pol", POL_OFF, DATA_W'(pol), RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        st_chk(1'b0, 1'b0, STATE_RST);
        rd_chk("pol", POL_OFF, DATA_ZERO, RESP_OKAY);
        print_verdict();
    end
endmodule

`default_nettype wire
